// >>> include/mdsh_pkg.sv
// Shared constants and types for the converter channel sequencing block
package mdsh_pkg;

    // Channel layout
    localparam int          NUM_OUT    = 32;
    localparam int          NUM_CHAN   = 33;
    localparam int          CODE_W     = 14;
    localparam int          IDX_W      = 6;
    localparam logic [5:0]  OFFSET_IDX = 6'h20;
    localparam logic [13:0] CODE_RESET = 14'h0000;
    localparam logic        BUSY_RESET = 1'h1;

    // Serial word layout, first bit received ends up most significant
    localparam int          WORD_SHORT     = 10;
    localparam int          WORD_LONG      = 24;
    localparam int          BITCNT_W       = 5;
    localparam int          MODE_MSB       = 9;
    localparam int          MODE_LSB       = 8;
    localparam int          CAL_BIT        = 7;
    localparam int          OFFSET_SEL_BIT = 6;
    localparam int          TEST_BIT       = 5;
    localparam int          ADDR_MSB       = 4;
    localparam int          ADDR_LSB       = 0;

    // Operating modes carried by the first two bits
    localparam logic [1:0]  MODE_SAMPLE_HOLD = 2'h0;
    localparam logic [1:0]  MODE_DIRECT      = 2'h1;
    localparam logic [1:0]  MODE_ACQ_READ    = 2'h2;
    localparam logic [1:0]  MODE_READ_ONLY   = 2'h3;

    // Timing at a 100 ns clock
    localparam int CLK_PERIOD_NS  = 100;
    localparam int RESET_MIN_NS   = 90;
    localparam int RESET_MAX_NS   = 200;
    localparam int ACQ_MAX_NS     = 16000;
    localparam int RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MAX_CYC  = RESET_MAX_NS / CLK_PERIOD_NS;
    localparam int ACQ_CYC        = ACQ_MAX_NS / CLK_PERIOD_NS;
    localparam int LOWCNT_W       = 3;
    localparam int ACQCNT_W       = 8;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ACQUIRE
    } mdsh_state_e;

endpackage : mdsh_pkg

// >>> hw/mdsh_gate_qualifier.sv
// Hold/reset pin synchroniser and low-pulse width qualifier
module mdsh_gate_qualifier (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Combined hold/reset pin
    input  wire logic trackResetPin,
    // Qualified results
    output logic      trackHigh,
    output logic      trackRise,
    output logic      resetPulse
);

    logic                            pinMeta_reg, pinSync_reg, pinPrev_reg;
    logic [mdsh_pkg::LOWCNT_W-1:0]   lowCount_reg, lowCount_next;
    logic                            trackHigh_reg, trackHigh_next;
    logic                            trackRise_reg, trackRise_next;
    logic                            resetPulse_reg, resetPulse_next;
    logic                            pinRise;

    localparam logic [mdsh_pkg::LOWCNT_W-1:0] MinCyc = 3'(mdsh_pkg::RESET_MIN_CYC);
    localparam logic [mdsh_pkg::LOWCNT_W-1:0] MaxCyc = 3'(mdsh_pkg::RESET_MAX_CYC);
    localparam logic [mdsh_pkg::LOWCNT_W-1:0] SatCyc = 3'(mdsh_pkg::RESET_MAX_CYC + 1);

    assign pinRise = pinSync_reg && !pinPrev_reg;

    always_comb begin
        lowCount_next   = lowCount_reg;
        trackHigh_next  = pinSync_reg;
        trackRise_next  = 1'h0;
        resetPulse_next = 1'h0;
        if (!pinSync_reg) begin
            // Saturate just past the reset window: anything longer is a gate
            if (lowCount_reg != SatCyc) begin
                lowCount_next = lowCount_reg + 3'h1;
            end
        end else begin
            lowCount_next = '0;
        end
        if (pinRise) begin
            if (lowCount_reg >= MinCyc && lowCount_reg <= MaxCyc) begin
                resetPulse_next = 1'h1;
            end else if (lowCount_reg > MaxCyc) begin
                trackRise_next = 1'h1;
            end
            // Shorter lows fall through with no effect
        end
    end

    always_ff @(posedge clk) begin
        pinMeta_reg <= trackResetPin;
        pinSync_reg <= pinMeta_reg;
        if (!reset_n) begin
            pinPrev_reg    <= 1'h1;
            lowCount_reg   <= '0;
            trackHigh_reg  <= 1'h1;
            trackRise_reg  <= 1'h0;
            resetPulse_reg <= 1'h0;
        end else begin
            pinPrev_reg    <= pinSync_reg;
            lowCount_reg   <= lowCount_next;
            trackHigh_reg  <= trackHigh_next;
            trackRise_reg  <= trackRise_next;
            resetPulse_reg <= resetPulse_next;
        end
    end

    assign trackHigh  = trackHigh_reg;
    assign trackRise  = trackRise_reg;
    assign resetPulse = resetPulse_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pulse_width_ok_a: assert property (
        resetPulse |-> $past(lowCount_reg) >= MinCyc && $past(lowCount_reg) <= MaxCyc)
        else $error("reset pulse from a low of wrong width");
    pulse_exclusive_a: assert property (
        !(resetPulse && trackRise))
        else $error("reset and gate rise together");

endmodule : mdsh_gate_qualifier

// >>> hw/mdsh_channel_control.sv
// Channel code storage, serial command decode and sample-and-hold sequencing
//
// Overview of operation
// - Power-on clears all 33 channel codes
// - Low pulse 90-200 ns resets everything but the gate qualifier
// - Low pulse under 90 ns is ignored
// - Longer low acts as acquire gate
// - Buffer follows input, then takes new code
// - Acquisition ends within 16 us
// - Code held until channel addressed again
// - Gate high: acquire as soon as addressed
// - Gate low: route input, wait for rise
// - Busy low throughout each acquisition
// - Direct mode loads 14-bit code by address
// - Code applied once address and code complete
// - Offset channel acquirable like output channels
// - Direct mode writes offset channel code
// - First two bits select operating mode
module mdsh_channel_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Combined hold/reset pin
    input  wire logic        trackResetPin,
    // Serial port
    input  wire logic        sclk,
    input  wire logic        syncN,
    input  wire logic        serialIn,
    // Code from the acquisition converter, same clock
    input  wire logic [13:0] sampleCode,
    // Channel results
    output logic [13:0]      dacCode [mdsh_pkg::NUM_OUT],
    output logic [13:0]      offsetChannelOutput,
    output logic [32:0]      followInput,
    output logic             busyN
);

    localparam int AcqLim = mdsh_pkg::ACQ_CYC;

    logic trackHigh, trackRise, resetPulse, clearAll;

    mdsh_gate_qualifier u_gate (
        .clk           (clk),
        .reset_n       (reset_n),
        .trackResetPin (trackResetPin),
        .trackHigh     (trackHigh),
        .trackRise     (trackRise),
        .resetPulse    (resetPulse)
    );

    // Qualified reset pulse returns the serial port, sequencer and codes to power-on state; the gate qualifier keeps its state
    assign clearAll = !reset_n || resetPulse;

    function automatic logic [5:0] chanIndex(input logic [9:0] word);
        chanIndex = word[mdsh_pkg::OFFSET_SEL_BIT] ? mdsh_pkg::OFFSET_IDX
                                                   : {1'h0, word[mdsh_pkg::ADDR_MSB:mdsh_pkg::ADDR_LSB]};
    endfunction : chanIndex

    // Serial port pins, two flops each before use
    logic sclkMeta_reg, sclkSync_reg, sclkPrev_reg;
    logic syncMeta_reg, syncSync_reg, syncPrev_reg;
    logic dinMeta_reg,  dinSync_reg;
    logic sclkFall, syncFall;

    assign sclkFall = !sclkSync_reg && sclkPrev_reg;
    assign syncFall = !syncSync_reg && syncPrev_reg;

    logic                           frame_reg,    frame_next;
    logic [mdsh_pkg::BITCNT_W-1:0]  bitCount_reg, bitCount_next;
    logic [23:0]                    shift_reg,    shift_next;
    logic                           cmdPulse_reg, cmdPulse_next;
    logic                           dacPulse_reg, dacPulse_next;

    always_comb begin
        frame_next    = frame_reg;
        bitCount_next = bitCount_reg;
        shift_next    = shift_reg;
        cmdPulse_next = 1'h0;
        dacPulse_next = 1'h0;
        // Further frame-sync edges are ignored until the word is complete
        if (syncFall && !frame_reg) begin
            frame_next    = 1'h1;
            bitCount_next = '0;
        end else if (frame_reg && sclkFall) begin
            shift_next    = {shift_reg[22:0], dinSync_reg};
            bitCount_next = bitCount_reg + 5'h1;
            if (bitCount_next == 5'(mdsh_pkg::WORD_SHORT) &&
                shift_next[mdsh_pkg::MODE_MSB:mdsh_pkg::MODE_LSB] != mdsh_pkg::MODE_DIRECT) begin
                frame_next    = 1'h0;
                cmdPulse_next = 1'h1;
            end else if (bitCount_next == 5'(mdsh_pkg::WORD_LONG)) begin
                frame_next    = 1'h0;
                dacPulse_next = 1'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        sclkMeta_reg <= sclk;
        sclkSync_reg <= sclkMeta_reg;
        syncMeta_reg <= syncN;
        syncSync_reg <= syncMeta_reg;
        dinMeta_reg  <= serialIn;
        dinSync_reg  <= dinMeta_reg;
        if (clearAll) begin
            sclkPrev_reg <= 1'h1;
            syncPrev_reg <= 1'h1;
            frame_reg    <= 1'h0;
            bitCount_reg <= '0;
            shift_reg    <= '0;
            cmdPulse_reg <= 1'h0;
            dacPulse_reg <= 1'h0;
        end else begin
            sclkPrev_reg <= sclkSync_reg;
            syncPrev_reg <= syncSync_reg;
            frame_reg    <= frame_next;
            bitCount_reg <= bitCount_next;
            shift_reg    <= shift_next;
            cmdPulse_reg <= cmdPulse_next;
            dacPulse_reg <= dacPulse_next;
        end
    end

    // Shift register stays frozen after the frame, so words are read in place
    logic [9:0]  shortWord;
    logic [9:0]  longAddr;
    logic [13:0] longCode;
    logic [1:0]  cmdMode;
    logic        cmdAcquire;

    assign shortWord  = shift_reg[9:0];
    assign longAddr   = shift_reg[23:14];
    assign longCode   = shift_reg[13:0];
    assign cmdMode    = shortWord[mdsh_pkg::MODE_MSB:mdsh_pkg::MODE_LSB];
    assign cmdAcquire = cmdPulse_reg &&
                        (cmdMode == mdsh_pkg::MODE_SAMPLE_HOLD || cmdMode == mdsh_pkg::MODE_ACQ_READ);

    // Acquisition sequencer
    mdsh_pkg::mdsh_state_e          state_reg,    state_next;
    logic [5:0]                     acqIdx_reg,   acqIdx_next;
    logic [mdsh_pkg::ACQCNT_W-1:0]  acqCount_reg, acqCount_next;
    logic                           busyN_reg,    busyN_next;
    logic [32:0]                    follow_reg,   follow_next;
    logic                           acqDone;

    always_comb begin
        state_next    = state_reg;
        acqIdx_next   = acqIdx_reg;
        acqCount_next = acqCount_reg;
        busyN_next    = busyN_reg;
        follow_next   = follow_reg;
        acqDone       = 1'h0;
        if (cmdAcquire) begin
            // Readdressing restarts; the buffer follows the input meanwhile
            acqIdx_next   = chanIndex(shortWord);
            follow_next   = 33'h1 << chanIndex(shortWord);
            acqCount_next = '0;
            if (trackHigh) begin
                state_next = mdsh_pkg::ST_ACQUIRE;
                busyN_next = 1'h0;
            end else begin
                state_next = mdsh_pkg::ST_ARMED;
                busyN_next = 1'h1;
            end
        end else begin
            unique case (state_reg)
                mdsh_pkg::ST_IDLE: begin
                end
                mdsh_pkg::ST_ARMED: begin
                    if (trackRise) begin
                        state_next = mdsh_pkg::ST_ACQUIRE;
                        busyN_next = 1'h0;
                    end
                end
                mdsh_pkg::ST_ACQUIRE: begin
                    acqCount_next = acqCount_reg + 8'h1;
                    if (acqCount_reg == 8'(mdsh_pkg::ACQ_CYC - 1)) begin
                        acqDone     = 1'h1;
                        busyN_next  = 1'h1;
                        follow_next = '0;
                        state_next  = mdsh_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (clearAll) begin
            state_reg    <= mdsh_pkg::ST_IDLE;
            acqIdx_reg   <= '0;
            acqCount_reg <= '0;
            busyN_reg    <= mdsh_pkg::BUSY_RESET;
            follow_reg   <= '0;
        end else begin
            state_reg    <= state_next;
            acqIdx_reg   <= acqIdx_next;
            acqCount_reg <= acqCount_next;
            busyN_reg    <= busyN_next;
            follow_reg   <= follow_next;
        end
    end

    // Code storage: flops, so a held code never droops
    logic [13:0] chanCode_reg [mdsh_pkg::NUM_CHAN];
    logic [32:0] chanZero;
    logic [5:0]  dacIdx;

    assign dacIdx = chanIndex(longAddr);

    genvar gi;
    generate
        for (gi = 0; gi < mdsh_pkg::NUM_CHAN; gi++) begin : g_chan
            logic [13:0] code_next;
            always_comb begin
                code_next = chanCode_reg[gi];
                if (dacPulse_reg && dacIdx == 6'(gi)) begin
                    code_next = longCode;
                end else if (acqDone && acqIdx_reg == 6'(gi)) begin
                    code_next = sampleCode;
                end
            end
            always_ff @(posedge clk) begin
                if (clearAll) begin
                    chanCode_reg[gi] <= mdsh_pkg::CODE_RESET;
                end else begin
                    chanCode_reg[gi] <= code_next;
                end
            end
            assign chanZero[gi] = chanCode_reg[gi] == mdsh_pkg::CODE_RESET;
            if (gi < mdsh_pkg::NUM_OUT) begin : g_out
                assign dacCode[gi] = chanCode_reg[gi];
            end

            chan_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
                !resetPulse && !(dacPulse_reg && dacIdx == 6'(gi)) && !(acqDone && acqIdx_reg == 6'(gi))
                |=> $stable(chanCode_reg[gi]))
                else $error("channel code changed without being addressed");
        end
    endgenerate

    assign offsetChannelOutput = chanCode_reg[mdsh_pkg::NUM_OUT];
    assign followInput         = follow_reg;
    assign busyN               = busyN_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    power_clear_a: assert property (@(posedge clk) disable iff (1'b0)
        !reset_n |=> &chanZero && busyN_reg && follow_reg == '0)
        else $error("codes not cleared at power-on");
    pulse_clear_a: assert property (
        resetPulse |=> &chanZero && state_reg == mdsh_pkg::ST_IDLE && !frame_reg)
        else $error("reset pulse did not clear the device");
    acq_bound_a: assert property (
        $fell(busyN_reg) |-> ##[1:AcqLim] (busyN_reg || $past(cmdAcquire) || $past(resetPulse)))
        else $error("acquisition ran too long");
    acq_store_a: assert property (
        acqDone && !resetPulse |=> chanCode_reg[$past(acqIdx_reg)] == $past(sampleCode) && follow_reg == '0)
        else $error("acquired code not stored");
    busy_follow_a: assert property (
        !busyN_reg |-> state_reg == mdsh_pkg::ST_ACQUIRE && follow_reg[acqIdx_reg])
        else $error("busy low outside an acquisition");
    gate_start_a: assert property (
        cmdAcquire && trackHigh && !resetPulse |=> !busyN_reg ##1 !busyN_reg)
        else $error("acquisition not started with gate high");
    gate_defer_a: assert property (
        cmdAcquire && !trackHigh && !resetPulse |=> busyN_reg && state_reg == mdsh_pkg::ST_ARMED)
        else $error("acquisition not deferred with gate low");
    armed_rise_a: assert property (
        state_reg == mdsh_pkg::ST_ARMED && trackRise && !cmdAcquire && !resetPulse |=> !busyN_reg)
        else $error("gate rise did not start acquisition");
    direct_load_a: assert property (
        dacPulse_reg && !resetPulse |=> chanCode_reg[$past(dacIdx)] == $past(longCode))
        else $error("direct code not applied");
    mode_split_a: assert property (
        cmdPulse_reg |-> cmdMode != mdsh_pkg::MODE_DIRECT && !dacPulse_reg)
        else $error("direct-code word ended early");

    offset_direct_c: cover property (dacPulse_reg && dacIdx == mdsh_pkg::OFFSET_IDX);
    deferred_acq_c:  cover property (state_reg == mdsh_pkg::ST_ARMED [*4] ##1 !busyN_reg);
    acq_done_c:      cover property (acqDone);
    reset_pulse_c:   cover property (resetPulse);

endmodule : mdsh_channel_control

// >>> tb/mdsh_host_model.sv
// Host model: serial port master and acquire gate driver
module mdsh_host_model (
    // Clock
    input  wire logic clk,
    // Serial port
    output logic      sclk,
    output logic      syncN,
    output logic      serialIn,
    // Combined hold/reset pin
    output logic      trackResetPin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Half serial period in clocks, above the synchroniser minimum
    localparam int HALF_CYC = 4;

    // Pin has a pull-up, so idle is high
    initial begin
        sclk          = 1'b1;
        syncN         = 1'b1;
        serialIn      = 1'b0;
        trackResetPin = 1'b1;
    end

    // Mode bits lead the word; short words stop after the address
    task automatic sendWord(input logic [23:0] word, input logic isLong);
        int n;
        n = isLong ? 24 : 10;
        @(negedge clk);
        syncN = 1'b0;
        repeat (HALF_CYC) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            sclk     = 1'b1;
            serialIn = word[23 - i];
            repeat (HALF_CYC) @(negedge clk);
            sclk = 1'b0;
            repeat (HALF_CYC) @(negedge clk);
        end
        sclk = 1'b1;
        repeat (HALF_CYC) @(negedge clk);
        // Released line must not keep showing the last bit
        serialIn = ~serialIn;
        syncN    = 1'b1;
        repeat (2 * HALF_CYC) @(negedge clk);
    endtask : sendWord

    task automatic setGate(input logic level);
        @(negedge clk);
        trackResetPin = level;
    endtask : setGate

    task automatic pulsePin(input int lowNs);
        @(negedge clk);
        trackResetPin = 1'b0;
        #(lowNs);
        trackResetPin = 1'b1;
    endtask : pulsePin

endmodule : mdsh_host_model

// >>> tb/tb_top.sv
// Self-checking bench for the channel sequencing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        reset_n;
    logic        sclk;
    logic        syncN;
    logic        serialIn;
    logic        trackResetPin;
    logic [13:0] sampleCode;
    logic [13:0] dacCode [mdsh_pkg::NUM_OUT];
    logic [13:0] offsetChannelOutput;
    logic [32:0] followInput;
    logic        busyN;
    logic [13:0] model [33];
    int          errCount;
    int          testsRun;
    int          busyLen;
    int          lastLen;

    mdsh_channel_control dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .trackResetPin       (trackResetPin),
        .sclk                (sclk),
        .syncN               (syncN),
        .serialIn            (serialIn),
        .sampleCode          (sampleCode),
        .dacCode             (dacCode),
        .offsetChannelOutput (offsetChannelOutput),
        .followInput         (followInput),
        .busyN               (busyN)
    );

    mdsh_host_model host (
        .clk           (clk),
        .sclk          (sclk),
        .syncN         (syncN),
        .serialIn      (serialIn),
        .trackResetPin (trackResetPin)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // Length of the last busy-low stretch
    always @(posedge clk) begin
        if (busyN === 1'b0) begin
            busyLen++;
        end else if (busyLen != 0) begin
            lastLen = busyLen;
            busyLen = 0;
        end
    end

    task automatic check(input logic ok, input string msg);
        testsRun++;
        if (ok !== 1'b1) begin
            errCount++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : check

    function automatic logic [13:0] codeOf(input int idx);
        return (idx == 32) ? offsetChannelOutput : dacCode[idx];
    endfunction : codeOf

    function automatic logic [23:0] mkWord(input logic [1:0] mode, input int idx, input logic [13:0] code);
        return {mode, 1'b0, (idx == 32), 1'b0, idx[4:0], code};
    endfunction : mkWord

    task automatic checkAll(input string msg);
        for (int i = 0; i < 33; i++) begin
            check(codeOf(i) === model[i], msg);
        end
    endtask : checkAll

    task automatic stopTest();
        $display("TB: %0d comparisons, %0d mismatches", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stopTest

    task automatic waitAcq(input int idx);
        int k;
        k = 0;
        lastLen = 0;
        while (busyN !== 1'b0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        check(busyN === 1'b0, "busy not low during acquisition");
        check(followInput === (33'h1 << idx), "buffer not following input");
        k = 0;
        while (busyN !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        check(lastLen > 0 && lastLen <= mdsh_pkg::ACQ_CYC, "acquisition too long");
        check(followInput === 33'h0, "buffer still on input");
        model[idx] = sampleCode;
        sampleCode = ~sampleCode;
        repeat (20) @(negedge clk);
        checkAll("code not held after acquisition");
    endtask : waitAcq

    task automatic testReset();
        for (int i = 0; i < 33; i++) model[i] = 14'h0000;
        checkAll("code not cleared at power-on");
        check(busyN === 1'b1 && followInput === 33'h0, "idle outputs wrong");
        $display("TB: reset test done");
    endtask : testReset

    task automatic testDirect();
        int          idx [4]  = '{0, 17, 31, 32};
        logic [13:0] code [4] = '{14'h3fff, 14'h1555, 14'h2aaa, 14'h0c3a};
        for (int i = 0; i < 4; i++) begin
            host.sendWord(mkWord(mdsh_pkg::MODE_DIRECT, idx[i], code[i]), 1'b1);
            model[idx[i]] = code[i];
            checkAll("direct code load wrong");
        end
        $display("TB: direct code test done");
    endtask : testDirect

    task automatic testTrackHigh();
        sampleCode = 14'h2d4b;
        host.sendWord(mkWord(mdsh_pkg::MODE_SAMPLE_HOLD, 9, 14'h0000), 1'b0);
        waitAcq(9);
        $display("TB: acquire on address test done");
    endtask : testTrackHigh

    task automatic testGate();
        host.setGate(1'b0);
        sampleCode = 14'h0a5c;
        host.sendWord(mkWord(mdsh_pkg::MODE_SAMPLE_HOLD, 32, 14'h0000), 1'b0);
        repeat (10) @(negedge clk);
        check(followInput === (33'h1 << 32), "input not routed while gate low");
        check(busyN === 1'b1, "acquired before gate rise");
        host.setGate(1'b1);
        waitAcq(32);
        $display("TB: gate test done");
    endtask : testGate

    task automatic testModes();
        sampleCode = 14'h1e0f;
        host.sendWord(mkWord(mdsh_pkg::MODE_ACQ_READ, 31, 14'h0000), 1'b0);
        waitAcq(31);
        host.sendWord(mkWord(mdsh_pkg::MODE_READ_ONLY, 0, 14'h0000), 1'b0);
        repeat (30) @(negedge clk);
        check(busyN === 1'b1 && followInput === 33'h0, "read-only mode acquired");
        checkAll("read-only mode changed a code");
        $display("TB: mode test done");
    endtask : testModes

    task automatic testPinReset();
        int ignoreNs [2] = '{40, 420};
        int resetNs [2]  = '{120, 190};
        for (int i = 0; i < 2; i++) begin
            host.pulsePin(ignoreNs[i]);
            repeat (10) @(negedge clk);
            checkAll("codes lost on short or long low");
        end
        for (int i = 0; i < 2; i++) begin
            host.sendWord(mkWord(mdsh_pkg::MODE_DIRECT, 3, 14'h2345), 1'b1);
            host.pulsePin(resetNs[i]);
            repeat (10) @(negedge clk);
            for (int j = 0; j < 33; j++) model[j] = 14'h0000;
            checkAll("pin reset did not clear codes");
            check(busyN === 1'b1 && followInput === 33'h0, "pin reset left outputs");
        end
        $display("TB: pin reset test done");
    endtask : testPinReset

    // Whole run is a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stopTest();
    end

    initial begin
        reset_n    = 1'b0;
        sampleCode = 14'h0000;
        errCount   = 0;
        testsRun   = 0;
        busyLen    = 0;
        lastLen    = 0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        testReset();
        testDirect();
        testTrackHigh();
        testGate();
        testModes();
        testPinReset();
        stopTest();
    end

endmodule : tb_top
